// ---- hdl/clock_deviation_monitor.sv ----
// main clock deviation monitor with oscillation-stop detection and apb registers
// assumes pclk is the main clock as seen by this block, the slow reference
// arrives as an asynchronous level, and the watchdog keeps that oscillator running
//
// Functional notes
// - a running average of main-clock counts per reference window is kept.
// - during learning the deviation check is off and no deviation error can be raised.
// - learning ends with an interrupt after 255 divided reference windows.
// - on that first interrupt the range comes from the average and checking turns on.
// - later interrupts mean the last count left the range, for the error handler.
// - only deviation from the learned start value is judged, no absolute check.
// - stop detection is active straight out of power-on reset.
// - a main clock stop switches to the reference oscillator and raises an nmi.
// - only the main clock is watched for stopping, never the reference.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module clock_deviation_monitor #(
   parameter int ref_div = clock_monitor_pkg::ref_div_default
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        slow_ref_osc,
   input  wire logic        main_clk_alive,
   output logic             irq,
   output logic             nmi,
   output logic             use_slow_clock
);
   localparam int cw = clock_monitor_pkg::count_width;

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   // scale a count by percent / 100
   function automatic logic [cw-1:0] pct_of(input logic [cw-1:0] v,
                                            input logic [clock_monitor_pkg::tol_width-1:0] p);
      logic [cw+7:0] prod;
      prod = v * p;
      return cw'(prod / 100);
   endfunction : pct_of

   // ---------------------------------------------
   // input synchronisers
   // ---------------------------------------------
   logic ref_s;
   logic alive_s;
   logic ref_d_r;
   logic ref_edge;
   logic window_tick;

   clk_sync ref_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (slow_ref_osc),
      .sync_out (ref_s)
   );
   clk_sync alive_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (main_clk_alive),
      .sync_out (alive_s)
   );
   assign ref_edge = ref_s & ~ref_d_r;
   window_divider #(.div(ref_div)) windows (
      .pclk        (pclk),
      .presetn     (presetn),
      .ref_edge    (ref_edge),
      .window_tick (window_tick)
   );

   // ---------------------------------------------
   // registers and state
   // ---------------------------------------------
   clock_monitor_pkg::mon_state_t state_r, state_nxt;
   logic [cw-1:0] count_r, count_nxt;
   logic [cw-1:0] avg_r, avg_nxt;
   logic [cw-1:0] lo_r, lo_nxt;
   logic [cw-1:0] hi_r, hi_nxt;
   logic [cw-1:0] last_r, last_nxt;
   logic [7:0]    win_r, win_nxt;
   logic [clock_monitor_pkg::tol_width-1:0] tol_r, tol_nxt;
   logic          nmi_en_r, nmi_en_nxt;
   logic [clock_monitor_pkg::st_width-1:0] status_r, status_nxt;
   logic [clock_monitor_pkg::st_width-1:0] mask_r, mask_nxt;
   logic [15:0]   stop_cnt_r, stop_cnt_nxt;
   logic          stopped_r, stopped_nxt;
   logic [31:0]   prdata_nxt;
   logic          wr_acc;
   logic          rd_acc;
   logic          mapped;
   logic [clock_monitor_pkg::st_width-1:0] ev;
   logic          stop_ev;
   logic [cw+1:0] avg_sum;

   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & ~penable & ~pwrite;

   always_comb begin
      case (paddr)
         clock_monitor_pkg::ctrl_off, clock_monitor_pkg::status_off,
         clock_monitor_pkg::mask_off, clock_monitor_pkg::average_off,
         clock_monitor_pkg::range_lo_off, clock_monitor_pkg::range_hi_off,
         clock_monitor_pkg::last_count_off: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // ---------------------------------------------
   // monitor state machine
   // ---------------------------------------------
   always_comb begin
      state_nxt  = state_r;
      count_nxt  = count_r;
      avg_nxt    = avg_r;
      lo_nxt     = lo_r;
      hi_nxt     = hi_r;
      last_nxt   = last_r;
      win_nxt    = win_r;
      tol_nxt    = tol_r;
      nmi_en_nxt = nmi_en_r;
      mask_nxt   = mask_r;
      ev         = '0;
      avg_sum    = '0;
      ev[clock_monitor_pkg::st_osc_stop_bit] = stop_ev;
      // count main clock cycles in each window, saturating
      if (window_tick) begin
         count_nxt = '0;
      end else if (count_r != {cw{1'b1}}) begin
         count_nxt = count_r + 1'b1;
      end
      case (state_r)
         clock_monitor_pkg::idle_st: begin
         end
         clock_monitor_pkg::learn_st: begin
            if (window_tick) begin
               last_nxt = count_r;
               avg_sum  = {2'b00, avg_r} + {2'b00, count_r};
               avg_nxt  = (win_r == 8'h00) ? count_r : cw'(avg_sum >> 1);
               win_nxt  = win_r + 8'h01;
               if (win_r == 8'(clock_monitor_pkg::learn_windows - 1)) begin
                  ev[clock_monitor_pkg::st_learn_done_bit] = 1'b1;
                  lo_nxt    = avg_nxt - pct_of(avg_nxt, tol_r);
                  hi_nxt    = avg_nxt + pct_of(avg_nxt, tol_r);
                  state_nxt = clock_monitor_pkg::watch_st;
               end
            end
         end
         clock_monitor_pkg::watch_st: begin
            if (window_tick) begin
               last_nxt = count_r;
               // deviation out of range, relative to learned value
               if (count_r < lo_r || count_r > hi_r) begin
                  ev[clock_monitor_pkg::st_deviation_bit] = 1'b1;
               end
            end
         end
         default: state_nxt = clock_monitor_pkg::idle_st;
      endcase
      if (wr_acc && paddr == clock_monitor_pkg::ctrl_off) begin
         tol_nxt    = pwdata[clock_monitor_pkg::ctrl_tol_lsb +: clock_monitor_pkg::tol_width];
         nmi_en_nxt = pwdata[clock_monitor_pkg::ctrl_nmi_en_bit];
         if (pwdata[clock_monitor_pkg::ctrl_start_bit]) begin
            state_nxt = clock_monitor_pkg::learn_st;
            win_nxt   = 8'h00;
            avg_nxt   = '0;
            lo_nxt    = '0;
            hi_nxt    = '0;
         end
      end
      if (wr_acc && paddr == clock_monitor_pkg::mask_off) begin
         mask_nxt = pwdata[clock_monitor_pkg::st_width-1:0];
      end
   end

   // ---------------------------------------------
   // oscillation stop detect
   // ---------------------------------------------
   // a missing activity toggle for stop_limit reference edges means stopped;
   // counted on the reference since the main clock itself may be gone
   logic alive_d_r;
   always_comb begin
      stop_cnt_nxt = stop_cnt_r;
      stopped_nxt  = stopped_r;
      // only main clock activity is watched
      if (alive_s != alive_d_r) begin
         stop_cnt_nxt = 16'h0000;
      end else if (ref_edge && !stopped_r) begin
         stop_cnt_nxt = stop_cnt_r + 16'h0001;
      end
      // armed from reset, switch to reference clock
      if (stop_cnt_r == 16'(clock_monitor_pkg::stop_limit)) begin
         stopped_nxt = 1'b1;
      end
      stop_ev = stopped_nxt & ~stopped_r;
   end

   // stays switched until reset; there is no software path back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_cnt_r <= 16'h0000;
         stopped_r  <= 1'b0;
         alive_d_r  <= 1'b0;
      end else begin
         stop_cnt_r <= stop_cnt_nxt;
         stopped_r  <= stopped_nxt;
         alive_d_r  <= alive_s;
      end
   end

   // ---------------------------------------------
   // status, interrupts and read data
   // ---------------------------------------------
   always_comb begin
      status_nxt = status_r;
      if (wr_acc && paddr == clock_monitor_pkg::status_off) begin
         status_nxt = status_r & ~pwdata[clock_monitor_pkg::st_width-1:0];
      end
      // set wins over write-one clear
      status_nxt = status_nxt | ev;
      prdata_nxt = prdata;
      if (rd_acc) begin
         case (paddr)
            clock_monitor_pkg::ctrl_off: prdata_nxt = 32'({tol_r, 6'h00, nmi_en_r, 1'b0}) |
                                                      32'({state_r, 16'h0000});
            clock_monitor_pkg::status_off:     prdata_nxt = 32'(status_r);
            clock_monitor_pkg::mask_off:       prdata_nxt = 32'(mask_r);
            clock_monitor_pkg::average_off:    prdata_nxt = 32'(avg_r);
            clock_monitor_pkg::range_lo_off:   prdata_nxt = 32'(lo_r);
            clock_monitor_pkg::range_hi_off:   prdata_nxt = 32'(hi_r);
            clock_monitor_pkg::last_count_off: prdata_nxt = 32'(last_r);
            default:                           prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // registered pins, so nothing on them can glitch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r       <= '0;
         prdata         <= 32'h0000_0000;
         pready         <= 1'b0;
         pslverr        <= 1'b0;
         irq            <= 1'b0;
         nmi            <= 1'b0;
         use_slow_clock <= 1'b0;
      end else begin
         status_r       <= status_nxt;
         prdata         <= prdata_nxt;
         pready         <= psel & ~penable;
         pslverr        <= psel & ~penable & ~mapped;
         irq            <= |(status_nxt[1:0] & mask_nxt[1:0]);
         // nmi for stop, gated by nmi enable
         nmi            <= status_nxt[clock_monitor_pkg::st_osc_stop_bit] & nmi_en_nxt;
         use_slow_clock <= stopped_nxt;
      end
   end

   // ---------------------------------------------
   // monitor registers
   // ---------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r        <= clock_monitor_pkg::idle_st;
         count_r        <= '0;
         avg_r          <= '0;
         lo_r           <= '0;
         hi_r           <= '0;
         last_r         <= '0;
         win_r          <= 8'h00;
         tol_r          <= clock_monitor_pkg::tol_reset;
         nmi_en_r       <= clock_monitor_pkg::nmi_en_reset;
         mask_r         <= clock_monitor_pkg::mask_reset;
         ref_d_r        <= 1'b0;
      end else begin
         state_r        <= state_nxt;
         count_r        <= count_nxt;
         avg_r          <= avg_nxt;
         lo_r           <= lo_nxt;
         hi_r           <= hi_nxt;
         last_r         <= last_nxt;
         win_r          <= win_nxt;
         tol_r          <= tol_nxt;
         nmi_en_r       <= nmi_en_nxt;
         mask_r         <= mask_nxt;
         ref_d_r        <= ref_s;
      end
   end
endmodule : clock_deviation_monitor

// ---- hdl/clock_monitor_pkg.sv ----
// package of constants for the main clock deviation monitor
// assumes a single pclk domain and an apb register port
package clock_monitor_pkg;
   localparam logic [11:0] ctrl_off       = 12'h000;
   localparam logic [11:0] status_off     = 12'h004;
   localparam logic [11:0] mask_off       = 12'h008;
   localparam logic [11:0] average_off    = 12'h00c;
   localparam logic [11:0] range_lo_off   = 12'h010;
   localparam logic [11:0] range_hi_off   = 12'h014;
   localparam logic [11:0] last_count_off = 12'h018;
   // ctrl fields
   localparam int ctrl_start_bit   = 0;
   localparam int ctrl_nmi_en_bit  = 1;
   localparam int ctrl_tol_lsb     = 8;
   localparam int tol_width        = 7;
   // status / mask fields
   localparam int st_learn_done_bit = 0;
   localparam int st_deviation_bit  = 1;
   localparam int st_osc_stop_bit   = 2;
   localparam int st_width          = 3;
   // reset values
   localparam logic [tol_width-1:0] tol_reset  = 7'h05;
   localparam logic [st_width-1:0]  mask_reset = 3'h0;
   localparam logic                 nmi_en_reset = 1'b1;
   // timing
   localparam int learn_windows   = 255;
   localparam int ref_div_default = 8;
   localparam int stop_limit      = 64;
   localparam int count_width     = 24;
   typedef enum logic [1:0] {idle_st, learn_st, watch_st} mon_state_t;
endpackage : clock_monitor_pkg

// ---- hdl/clk_sync.sv ----
// two flip-flop synchroniser for a level from another domain
// assumes destination clock pclk and async active-low reset
`timescale 1ns/1ns
module clk_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : clk_sync

// ---- hdl/window_divider.sv ----
// divides synchronised reference edges into one-cycle window pulses
// assumes the reference edge pulse is already in the pclk domain
`timescale 1ns/1ns
module window_divider #(
   parameter int div = 8
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ref_edge,
   output logic      window_tick
);
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic        tick_nxt;
   always_comb begin
      cnt_nxt  = cnt_r;
      tick_nxt = 1'b0;
      if (ref_edge) begin
         if (cnt_r == 16'(div - 1)) begin
            cnt_nxt  = 16'h0000;
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 16'h0001;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r       <= 16'h0000;
         window_tick <= 1'b0;
      end else begin
         cnt_r       <= cnt_nxt;
         window_tick <= tick_nxt;
      end
   end
endmodule : window_divider

// ---- verification/clock_deviation_monitor_asserts.sv ----
// port checker for the clock deviation monitor
// assumes one pclk domain; bound to every monitor instance
`timescale 1ns/1ns
module clock_deviation_monitor_asserts (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        slow_ref_osc,
   input wire logic        main_clk_alive,
   input wire logic        irq,
   input wire logic        nmi,
   input wire logic        use_slow_clock
);
   // ----------------------------------
   // bus answer and clock fault outputs
   // ----------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   apb_answer_a: assert property (setup_s ##1 access_s |-> pready)
      else $error("pready missing in access cycle");
   ready_place_a: assert property (pready |-> access_s)
      else $error("pready outside access cycle");
   ready_single_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   err_place_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   reset_quiet_a: assert property ($rose(presetn) |-> !irq && !nmi && !use_slow_clock)
      else $error("outputs active after reset");
   slow_sticky_a: assert property (use_slow_clock |=> use_slow_clock)
      else $error("slow clock selection dropped");
   nmi_cause_a: assert property ($rose(nmi) |-> ##[0:2] use_slow_clock)
      else $error("nmi without slow clock switch");
endmodule : clock_deviation_monitor_asserts
bind clock_deviation_monitor clock_deviation_monitor_asserts chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .slow_ref_osc(slow_ref_osc), .main_clk_alive(main_clk_alive), .irq(irq), .nmi(nmi),
   .use_slow_clock(use_slow_clock));

// ---- verification/clock_deviation_monitor_tb_top.sv ----
// self-checking bench for the clock deviation monitor
// assumes ref_div 1, so one window is one reference period
`timescale 1ns/1ns
module clock_deviation_monitor_tb_top;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr;
   logic        slow_ref_osc   = 1'b0;
   logic        main_clk_alive = 1'b0;
   logic        alive_run, irq, nmi, use_slow_clock;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, avg, lfsr;
   logic [32:0] notes[$];
   int          err_total, samples_checked, ref_half, rcnt, cyc, c0;
   clock_deviation_monitor #(.ref_div(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .slow_ref_osc(slow_ref_osc), .main_clk_alive(main_clk_alive), .irq(irq), .nmi(nmi),
      .use_slow_clock(use_slow_clock));
   always #5 pclk = ~pclk;
   // ----------------------------------
   // tasks
   // ----------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   task automatic cmp(input string what, input logic [32:0] exp, input logic [32:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic flag(input string what, input logic exp, input logic got);
      cmp(what, {32'h0, exp}, {32'h0, got});
   endtask : flag
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test
   // one edge of idle after each transfer keeps every assignment in its own time step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; n == 0 || pready !== 1'b1; n++) begin
         if (n == 30) begin
            flag("pready wait", 1'b1, 1'b0);
            finish_test();
         end
         @(posedge pclk);
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      notes.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic wait_hi(input logic on_nmi, input int lim);
      for (int n = 0; (on_nmi ? nmi : irq) !== 1'b1; n++) begin
         if (n == lim) begin
            flag("flag wait", 1'b1, 1'b0);
            finish_test();
         end
         @(posedge pclk);
      end
   endtask : wait_hi
   // reference toggles every ref_half cycles, activity every 4; also the read watcher
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      rcnt <= (rcnt + 1 >= ref_half) ? 0 : rcnt + 1;
      if (ref_half != 0 && rcnt + 1 >= ref_half) slow_ref_osc <= ~slow_ref_osc;
      if (alive_run && cyc % 4 == 0) main_clk_alive <= ~main_clk_alive;
      if (psel && penable && pready && !pwrite && notes.size() > 0) cmp("read", notes.pop_front(), {pslverr, prdata});
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      alive_run = 1'b0;
      lfsr = 32'h3313;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(clock_monitor_pkg::ctrl_off, 33'h0_0000_0502);
      for (int a = 4; a <= 24; a += 4) rd(a[11:0], 33'h0);
      rd(12'h01c, 33'h1_0000_0000);
      repeat (300) @(posedge pclk);
      flag("still ref nmi", 1'b0, nmi);
      $display("test reset_values done");
      ref_half <= 20;
      alive_run <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         apb(1'b1, clock_monitor_pkg::ctrl_off, {17'h0, lfsr[14:8], 6'h0, lfsr[1], 1'b0});
         rd(clock_monitor_pkg::ctrl_off, {18'h0, lfsr[14:8], 6'h0, lfsr[1], 1'b0});
      end
      apb(1'b1, clock_monitor_pkg::mask_off, 32'h3);
      apb(1'b1, clock_monitor_pkg::ctrl_off, 32'h503);
      c0 = cyc;
      rd(clock_monitor_pkg::ctrl_off, 33'h0_0001_0502);
      repeat (2000) @(posedge pclk);
      flag("learn irq", 1'b0, irq);
      wait_hi(1'b0, 12000);
      flag("learn span", 1'b1, cyc - c0 > 254 * 40 && cyc - c0 < 256 * 40);
      rd(clock_monitor_pkg::status_off, 33'h1);
      rd(clock_monitor_pkg::ctrl_off, 33'h0_0002_0502);
      apb(1'b0, clock_monitor_pkg::average_off, 32'h0);
      avg = q;
      flag("average", 1'b1, avg >= 38 && avg <= 40);
      rd(clock_monitor_pkg::range_lo_off, {1'b0, avg - avg * 5 / 100});
      rd(clock_monitor_pkg::range_hi_off, {1'b0, avg + avg * 5 / 100});
      apb(1'b1, clock_monitor_pkg::status_off, 32'h1);
      repeat (400) @(posedge pclk);
      flag("steady irq", 1'b0, irq);
      $display("test learning done");
      ref_half <= 10;
      wait_hi(1'b0, 400);
      rd(clock_monitor_pkg::status_off, 33'h2);
      apb(1'b1, clock_monitor_pkg::mask_off, 32'h1);
      repeat (2) @(posedge pclk);
      flag("masked irq", 1'b0, irq);
      ref_half <= 20;
      repeat (400) @(posedge pclk);
      apb(1'b1, clock_monitor_pkg::status_off, 32'h2);
      apb(1'b1, clock_monitor_pkg::mask_off, 32'h3);
      repeat (2) @(posedge pclk);
      flag("cleared irq", 1'b0, irq);
      rd(clock_monitor_pkg::range_lo_off, {1'b0, avg - avg * 5 / 100});
      $display("test deviation done");
      alive_run <= 1'b0;
      wait_hi(1'b1, 4000);
      flag("slow clock", 1'b1, use_slow_clock);
      flag("stop irq", 1'b0, irq);
      rd(clock_monitor_pkg::status_off, 33'h4);
      apb(1'b1, clock_monitor_pkg::ctrl_off, 32'h500);
      repeat (2) @(posedge pclk);
      flag("nmi off", 1'b0, nmi);
      alive_run <= 1'b1;
      repeat (100) @(posedge pclk);
      flag("slow kept", 1'b1, use_slow_clock);
      $display("test stop done");
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(clock_monitor_pkg::ctrl_off, 33'h0_0000_0502);
      rd(clock_monitor_pkg::average_off, 33'h0);
      rd(clock_monitor_pkg::range_hi_off, 33'h0);
      flag("slow reset", 1'b0, use_slow_clock);
      alive_run <= 1'b0;
      wait_hi(1'b1, 4000);
      $display("test reset_restart done");
      finish_test();
   end
endmodule : clock_deviation_monitor_tb_top
